/* File: core/dsc_pkg.sv */
// Notes on behaviour
// - Data out shows bit shifted out of last stage
// - Launch edge: falling mode 0, rising mode 1
// - Mode 0 lag is 12.5 clocks
// - Mode 1 lag is 12 clocks
// - Power-up phase is mode 0
// - Data out always driven, never floats
// - Data out frozen while select high
// - Host uses polarity and phase zero
// - Polarity/phase one only ignoring data out
// - Host idles clock low, toggles only updating
// - Chain: data out feeds next data in
// - No-op passes data, registers untouched
// - One select rise, all devices act together
// - Output equals code times reference over 256
// - Command 11/10 sets mode 1, updates DACs
// - Command 10/10 sets mode 0, updates DACs
// - Phase held until reset or opposite command
// - All-zero control nibble is no-op
package dsc_pkg;
    localparam int WORD_W = 12;
    localparam int FIFO_DEPTH = 4;
    localparam int ADDR_HI = 11;
    localparam int ADDR_LO = 10;
    localparam int CTL_HI = 9;
    localparam int CTL_LO = 8;
    localparam int DATA_HI = 7;
    localparam int SYS_CLK_MHZ = 100;
    localparam int SCLK_HALF_NS = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] HALF_LOAD = 4'(SCLK_HALF_CYC - 1);
    localparam logic [3:0] LAST_BIT = 4'(WORD_W - 1);
    localparam logic PHASE_RST = 1'b0;
    localparam logic [1:0] CTL_LOAD = 2'h1;
    localparam logic [1:0] CTL_LOAD_UPD = 2'h3;
    localparam logic [1:0] CTL_SPECIAL = 2'h0;
    localparam logic [1:0] CTL_AUX = 2'h2;
    localparam logic [1:0] ADR_NO_OP = 2'h0;
    localparam logic [1:0] ADR_UPDATE = 2'h1;
    localparam logic [1:0] ADR_LOAD_ALL = 2'h2;
    localparam logic [1:0] ADR_PHASE1 = 2'h3;
    localparam logic [1:0] ADR_PHASE0 = 2'h2;
    localparam logic [7:0] CODE_RST = 8'h00;
endpackage

/* File: core/dsc_if.sv */
`timescale 1ns/1ns
interface dsc_if;
    logic sclk;
    logic din;
    logic cs_n;
    logic dout;
    modport host (output sclk, output din, output cs_n, input dout);
    modport dev (input sclk, input din, input cs_n, output dout);
endinterface

/* File: core/dsc_fifo.sv */
`timescale 1ns/1ns
module dsc_fifo #(
    parameter int W = 13,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic rdy;
    } dsc_fifo_st_t;
    dsc_fifo_st_t s_q, s_d;
    logic push, pop;

    assign in_ready = s_q.rdy;
    assign out_valid = s_q.cnt != '0;
    assign out_data = s_q.mem[s_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        // Registered room flag keeps ready straight from a flop
        s_d.rdy = s_d.cnt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* File: core/dsc_device.sv */
`timescale 1ns/1ns
module dsc_device
    import dsc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Serial link
    dsc_if.dev link,
    // Analog model
    input wire logic [7:0] vref_code,
    output logic [3:0][7:0] dac_code_value,
    output logic [3:0][7:0] vout,
    output logic phase_mode
);
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] ck_s;
        logic [1:0] di_s;
        logic [WORD_W-1:0] sr;
        logic hold;
        logic dout;
        logic phase;
        logic [3:0][7:0] inreg;
        logic [3:0][7:0] dacreg;
        logic [3:0][7:0] vout;
    } dsc_dev_st_t;
    dsc_dev_st_t s_q, s_d;
    logic rise, fall, cs_low, cs_rise;
    logic [1:0] adr, ctl;
    logic [7:0] dat;

    function automatic logic [7:0] dac_scale(logic [7:0] code,
                                             logic [7:0] ref_v);
        logic [15:0] prod;
        prod = 16'(code) * 16'(ref_v);
        return prod[15:8];
    endfunction

    assign rise = s_q.ck_s[1] && !s_q.ck_s[2];
    assign fall = !s_q.ck_s[1] && s_q.ck_s[2];
    assign cs_low = !s_q.cs_s[1];
    assign cs_rise = s_q.cs_s[1] && !s_q.cs_s[2];
    assign adr = s_q.sr[ADDR_HI:ADDR_LO];
    assign ctl = s_q.sr[CTL_HI:CTL_LO];
    assign dat = s_q.sr[DATA_HI:0];

    always_comb begin
        s_d = s_q;
        s_d.cs_s = {s_q.cs_s[1:0], link.cs_n};
        s_d.ck_s = {s_q.ck_s[1:0], link.sclk};
        s_d.di_s = {s_q.di_s[0], link.din};
        // Shift and launch only while selected
        if (cs_low && rise) begin
            s_d.sr = {s_q.sr[WORD_W-2:0], s_q.di_s[1]};
            s_d.hold = s_q.sr[WORD_W-1];
            if (s_q.phase) begin
                s_d.dout = s_q.sr[WORD_W-1];
            end
        end
        if (cs_low && fall && !s_q.phase) begin
            s_d.dout = s_q.hold;
        end
        // Decode at select rise; unlisted commands change nothing
        if (cs_rise) begin
            case (ctl)
                CTL_LOAD: begin
                    s_d.inreg[adr] = dat;
                end
                CTL_LOAD_UPD: begin
                    s_d.inreg[adr] = dat;
                    s_d.dacreg = s_d.inreg;
                end
                CTL_SPECIAL: begin
                    case (adr)
                        ADR_UPDATE: s_d.dacreg = s_q.inreg;
                        ADR_LOAD_ALL: s_d.dacreg = {4{dat}};
                        default: s_d.dacreg = s_q.dacreg;
                    endcase
                end
                CTL_AUX: begin
                    case (adr)
                        ADR_PHASE1: begin
                            s_d.phase = 1'b1;
                            s_d.dacreg = s_q.inreg;
                        end
                        ADR_PHASE0: begin
                            s_d.phase = 1'b0;
                            s_d.dacreg = s_q.inreg;
                        end
                        default: s_d.phase = s_q.phase;
                    endcase
                end
                default: s_d.phase = s_q.phase;
            endcase
        end
        for (int i = 0; i < 4; i++) begin
            s_d.vout[i] = dac_scale(s_q.dacreg[i], vref_code);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.cs_s <= 3'h7;
            s_q.phase <= PHASE_RST;
            s_q.inreg <= {4{CODE_RST}};
            s_q.dacreg <= {4{CODE_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.dout = s_q.dout;
    assign dac_code_value = s_q.dacreg;
    assign vout = s_q.vout;
    assign phase_mode = s_q.phase;
endmodule

/* File: core/dsc_host.sv */
`timescale 1ns/1ns
module dsc_host
    import dsc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Serial link
    dsc_if.host link,
    // Word input
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [WORD_W-1:0] tx_data,
    input wire logic tx_last,
    // Readback
    output logic [WORD_W-1:0] rx_word,
    output logic rx_valid,
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOW = 3'b001,
        ST_HIGH = 3'b010,
        ST_NEXT = 3'b011,
        ST_END = 3'b100,
        ST_GAP = 3'b101
    } dsc_host_state_t;
    typedef struct packed {
        dsc_host_state_t st;
        logic [3:0] cnt;
        logic [3:0] bitn;
        logic [WORD_W-1:0] word;
        logic last;
        logic [WORD_W-1:0] rx;
        logic [WORD_W-1:0] rx_out;
        logic rx_vld;
        logic sclk;
        logic din;
        logic cs_n;
        logic [1:0] do_s;
        logic busy;
    } dsc_host_st_t;
    dsc_host_st_t s_q, s_d;
    logic f_valid, f_ready;
    logic [WORD_W:0] f_data;

    dsc_fifo #(.W(WORD_W + 1), .DEPTH(FIFO_DEPTH)) dsc_fifo_inst (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data({tx_last, tx_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign f_ready = (s_q.st == ST_IDLE || s_q.st == ST_NEXT) && f_valid;

    always_comb begin
        s_d = s_q;
        s_d.do_s = {s_q.do_s[0], link.dout};
        s_d.rx_vld = 1'b0;
        if (f_ready) begin
            s_d.word = f_data[WORD_W-1:0];
            s_d.last = f_data[WORD_W];
            s_d.din = f_data[WORD_W-1];
            s_d.cs_n = 1'b0;
            s_d.bitn = '0;
            s_d.cnt = HALF_LOAD;
            s_d.st = ST_LOW;
        end
        case (s_q.st)
            ST_IDLE: begin
                s_d.sclk = 1'b0;
            end
            ST_LOW: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end else begin
                    s_d.sclk = 1'b1;
                    s_d.cnt = HALF_LOAD;
                    s_d.st = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end else begin
                    s_d.sclk = 1'b0;
                    s_d.rx = {s_q.rx[WORD_W-2:0], s_q.do_s[1]};
                    s_d.cnt = HALF_LOAD;
                    if (s_q.bitn == LAST_BIT) begin
                        s_d.rx_out = {s_q.rx[WORD_W-2:0], s_q.do_s[1]};
                        s_d.rx_vld = 1'b1;
                        s_d.st = s_q.last ? ST_END : ST_NEXT;
                    end else begin
                        s_d.bitn = s_q.bitn + 1'b1;
                        s_d.word = {s_q.word[WORD_W-2:0], 1'b0};
                        s_d.din = s_q.word[WORD_W-2];
                        s_d.st = ST_LOW;
                    end
                end
            end
            ST_NEXT: begin
                s_d.sclk = 1'b0;
            end
            ST_END: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end else begin
                    s_d.cs_n = 1'b1;
                    s_d.cnt = HALF_LOAD;
                    s_d.st = ST_GAP;
                end
            end
            ST_GAP: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end else begin
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        s_d.busy = s_d.st != ST_IDLE;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.cs_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.sclk = s_q.sclk;
    assign link.din = s_q.din;
    assign link.cs_n = s_q.cs_n;
    assign rx_word = s_q.rx_out;
    assign rx_valid = s_q.rx_vld;
    assign busy = s_q.busy;
endmodule

/* File: dv/dsc_assertions.sv */
`timescale 1ns/1ns
module dsc_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Link
    input wire logic sclk,
    input wire logic din,
    input wire logic cs_n,
    input wire logic dout
);
    logic sclk_q;
    logic [2:0] since_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q <= 1'b0;
            since_q <= 3'h7;
        end else begin
            sclk_q <= sclk;
            if (sclk != sclk_q) begin
                since_q <= 3'h0;
            end else if (since_q != 3'h7) begin
                since_q <= since_q + 3'h1;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_frozen; cs_n && $past(cs_n, 4) |-> $stable(dout); endproperty
    a_frozen: assert property (p_frozen) else $error("dout moved");
    property p_idle; cs_n |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("sclk not idle");
    property p_edge; $changed(dout) |-> since_q < 3'h6; endproperty
    a_edge: assert property (p_edge) else $error("dout off edge");
    property p_start; $fell(cs_n) |-> !sclk [*4]; endproperty
    a_start: assert property (p_start) else $error("early sclk");
    property p_end; $rose(cs_n) |-> !sclk && $past(sclk, 4) == 1'b0;
    endproperty
    a_end: assert property (p_end) else $error("late sclk");
    property p_high; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
    a_high: assert property (p_high) else $error("sclk width");
    property p_din; sclk && $past(sclk) |-> $stable(din); endproperty
    a_din: assert property (p_din) else $error("din moved");
    property p_gap; $rose(cs_n) |=> cs_n [*8]; endproperty
    a_gap: assert property (p_gap) else $error("short gap");
    c_frame: cover property ($rose(cs_n));
    c_fall: cover property ($changed(dout) && !sclk);
    c_rise: cover property ($changed(dout) && sclk);
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import dsc_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic tx_valid = 1'b0;
    logic [WORD_W-1:0] tx_data = '0;
    logic tx_last = 1'b0;
    logic [7:0] vref_code = 8'h00;
    logic tx_ready, rx_valid, busy, phase_mode;
    logic [WORD_W-1:0] rx_word;
    logic [3:0][7:0] dac_code_value, vout;
    logic [WORD_W:0] sent_bits = '0;
    logic [WORD_W-1:0] exp_q[$];
    logic [7:0] inp[4] = '{default: 8'h00};
    logic [7:0] dac[4] = '{default: 8'h00};
    logic [3:0] other[3] = '{4'h2, 4'h6, 4'hc};
    logic phase = 1'b0;
    logic refused = 1'b0;
    int n_mismatch = 0;
    int n_checks = 0;
    dsc_if link_if();
    always #5 sys_clk = ~sys_clk;
    dsc_host dsc_host_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link_if),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .tx_last(tx_last), .rx_word(rx_word), .rx_valid(rx_valid),
        .busy(busy));
    dsc_device dsc_device_inst (.sys_clk(sys_clk), .rstn(rstn),
        .link(link_if), .vref_code(vref_code),
        .dac_code_value(dac_code_value), .vout(vout),
        .phase_mode(phase_mode));
    dsc_assertions dsc_assertions_inst (.sys_clk(sys_clk), .rstn(rstn),
        .sclk(link_if.sclk), .din(link_if.din), .cs_n(link_if.cs_n),
        .dout(link_if.dout));
    task cmp(input string what, input logic [11:0] e, input logic [11:0] s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task put(input logic [11:0] d, input logic l);
        int k;
        k = 0;
        tx_valid <= 1'b1;
        tx_data <= d;
        tx_last <= l;
        // Late-high sampling: mode 1 lags 12 bits, mode 0 lags 13
        exp_q.push_back(phase ? sent_bits[11:0] : sent_bits[12:1]);
        sent_bits = {sent_bits[0], d};
        do begin
            @(posedge sys_clk);
            k++;
            if (tx_ready !== 1'b1) refused = 1'b1;
        end while (tx_ready !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            n_mismatch++;
            stop_test;
        end
    endtask
    task frame(input int n, input logic [11:0] w);
        int k;
        logic [1:0] a;
        logic [1:0] c;
        k = 0;
        a = w[11:10];
        c = w[9:8];
        for (int i = 0; i < n - 1; i++) put(12'($urandom), 1'b0);
        put(w, 1'b1);
        tx_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        while ((busy !== 1'b0 || link_if.cs_n !== 1'b1) && k < 9000) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 9000) begin
            n_mismatch++;
            stop_test;
        end
        repeat (6) @(posedge sys_clk);
        if (c[0]) inp[a] = w[7:0];
        if (c == CTL_LOAD_UPD || (c == CTL_SPECIAL && a == ADR_UPDATE)
            || (c == CTL_AUX && a[1])) dac = inp;
        if (c == CTL_SPECIAL && a == ADR_LOAD_ALL) dac = '{4{w[7:0]}};
        if (c == CTL_AUX && a[1]) phase = a[0];
        cmp("phase", 12'(phase), 12'(phase_mode));
        for (int i = 0; i < 4; i++) begin
            cmp("dac", 12'(dac[i]), 12'(dac_code_value[i]));
            cmp("vout", 12'((16'(dac[i]) * 16'(vref_code)) >> 8),
                12'(vout[i]));
        end
        $display("frame %h done", w);
    endtask
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[ERR] rx_word expected none seen %h", rx_word);
            end else begin
                cmp("rx_word", exp_q.pop_front(), rx_word);
            end
        end
    end
    initial begin
        void'($urandom(32'h1e4068ed));
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        cmp("phase", 12'h000, 12'(phase_mode));
        cmp("dout", 12'h000, 12'(link_if.dout));
        vref_code <= 8'($urandom);
        frame(6, {ADR_LOAD_ALL, CTL_SPECIAL, 8'($urandom)});
        cmp("refused", 12'h001, 12'(refused));
        for (int i = 0; i < 4; i++) begin
            frame(1, {2'(i), CTL_LOAD, 8'($urandom)});
        end
        frame(2, {ADR_NO_OP, CTL_SPECIAL, 8'($urandom)});
        frame(1, {ADR_PHASE1, CTL_AUX, 8'h00});
        frame(3, {ADR_NO_OP, CTL_SPECIAL, 8'hff});
        frame(1, {2'h1, CTL_LOAD_UPD, 8'($urandom)});
        frame(1, {ADR_PHASE0, CTL_AUX, 8'h00});
        frame(1, {2'h2, CTL_LOAD, 8'($urandom)});
        frame(1, {ADR_UPDATE, CTL_SPECIAL, 8'h00});
        foreach (other[i]) frame(1, {other[i], 8'($urandom)});
        repeat (2) @(posedge sys_clk);
        cmp("pending", 12'h000, 12'(exp_q.size()));
        stop_test;
    end
endmodule
